/* rtl/dif_pkg.sv */
/*
 * Package of the on-board digital I/O block: register map, field layouts,
 * reset values, delay encodings, timing figures and the packed carriers.
 * Assumes a single 20 MHz clock and a plain strobe-style register port.
 */
package dif_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_IN = 16;
    localparam int NUM_OUT = 12;
    localparam int GRP_SIZE = 4;
    localparam int NUM_GRP = NUM_IN / GRP_SIZE;
    localparam int CNT_W = 19;

    // Register offsets; the two image bytes read inputs and write outputs.
    localparam logic [ADDR_W-1:0] ADR_IMG_LO = 8'h88;
    localparam logic [ADDR_W-1:0] ADR_IMG_HI = 8'h89;
    localparam logic [ADDR_W-1:0] ADR_RISE_LO = 8'h90;
    localparam logic [ADDR_W-1:0] ADR_RISE_HI = 8'h91;
    localparam logic [ADDR_W-1:0] ADR_FALL_LO = 8'h92;
    localparam logic [ADDR_W-1:0] ADR_FALL_HI = 8'h93;
    localparam logic [ADDR_W-1:0] ADR_DELAY = 8'h94;
    localparam logic [ADDR_W-1:0] ADR_ESTAT_LO = 8'h98;
    localparam logic [ADDR_W-1:0] ADR_ESTAT_HI = 8'h99;
    localparam logic [ADDR_W-1:0] ADR_LSTAT_LO = 8'h9A;
    localparam logic [ADDR_W-1:0] ADR_LSTAT_HI = 8'h9B;
    localparam logic [ADDR_W-1:0] ADR_EMASK_LO = 8'h9C;
    localparam logic [ADDR_W-1:0] ADR_EMASK_HI = 8'h9D;
    localparam logic [ADDR_W-1:0] ADR_LMASK_LO = 8'h9E;
    localparam logic [ADDR_W-1:0] ADR_LMASK_HI = 8'h9F;
    localparam logic [ADDR_W-1:0] ADR_SUPPLY = 8'hA0;
    localparam logic [ADDR_W-1:0] ADR_OUT_LO = 8'hA2;
    localparam logic [ADDR_W-1:0] ADR_OUT_HI = 8'hA3;

    // Only four output lines live in the second output byte.
    localparam logic [DATA_W-1:0] OUT_HI_MASK = 8'h0F;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [NUM_IN-1:0] BITS_ZERO = 16'h0000;

    // Inputs rated for the fast input frequency.
    localparam logic [NUM_IN-1:0] FAST_MASK = 16'h8ED8;

    // Delay selection codes, two bits per group.
    localparam logic [1:0] DLY_0P1 = 2'h0;
    localparam logic [1:0] DLY_0P5 = 2'h1;
    localparam logic [1:0] DLY_3 = 2'h2;
    localparam logic [1:0] DLY_15 = 2'h3;
    localparam logic [2*NUM_GRP-1:0] DELAY_RST = 8'hAA;

    // Delay times in nanoseconds and the clock period they are divided by.
    localparam int CLK_PERIOD_NS = 50;
    localparam int DLY_0P1_NS = 100000;
    localparam int DLY_0P5_NS = 500000;
    localparam int DLY_3_NS = 3000000;
    localparam int DLY_15_NS = 15000000;

    // Register port request from the controller core.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dif_bus_req_t;

    // Supply presence and fault sense levels.
    typedef struct packed {
        logic electronics_ok;
        logic outputs_ok;
        logic expansion_bus_ok;
        logic inputs_ok;
        logic sensor_supply_fault;
        logic output_overload;
    } dif_supply_t;

    // All status lamps of the block.
    typedef struct packed {
        logic [NUM_IN-1:0] input_lamp;
        logic electronics_supply_lamp;
        logic output_supply_lamp;
        logic expansion_bus_supply_lamp;
        logic input_supply_lamp;
        logic sensor_supply_fault_lamp;
        logic output_overload_fault_lamp;
    } dif_lamps_t;
endpackage

/* rtl/dif_input_filter.sv */
/*
 * One input delay filter: the output level follows the raw input only after
 * the raw level has differed from it for a programmed number of cycles.
 * Assumes the raw input is already synchronous to clock_i.
 */
`timescale 1ns/1ns
module dif_input_filter #(
    parameter int CW = 19
) (
    input wire logic clock_i, // System clock.
    input wire logic reset_n_i, // Asynchronous active-low reset.
    input wire logic raw_i, // Raw input level.
    input wire logic [CW-1:0] limit_i, // Cycles the new level must stand.
    output logic level_o // Filtered level.
);
    logic [CW-1:0] count_reg;
    logic level_reg;

    // Any return to the old level restarts the count, so short pulses vanish.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= '0;
            level_reg <= 1'b0;
        end else if (raw_i == level_reg) begin
            count_reg <= '0;
        end else if (count_reg >= limit_i - CW'(1)) begin
            count_reg <= '0;
            level_reg <= raw_i;
        end else begin
            count_reg <= count_reg + CW'(1);
        end
    end

    assign level_o = level_reg;
endmodule // dif_input_filter

/* rtl/dif_onboard_io.sv */
/*
 * On-board digital I/O block: sixteen filtered inputs with edge interrupts,
 * interrupt-lost diagnostics, twelve outputs and the status lamps.
 * Assumes field inputs and supply sense levels are synchronous to clock_i.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
module dif_onboard_io #(
    parameter int unsigned CNT_0P1 = dif_pkg::DLY_0P1_NS / dif_pkg::CLK_PERIOD_NS,
    parameter int unsigned CNT_0P5 = dif_pkg::DLY_0P5_NS / dif_pkg::CLK_PERIOD_NS,
    parameter int unsigned CNT_3 = dif_pkg::DLY_3_NS / dif_pkg::CLK_PERIOD_NS,
    parameter int unsigned CNT_15 = dif_pkg::DLY_15_NS / dif_pkg::CLK_PERIOD_NS
) (
    input wire logic clock_i, // 20 MHz system clock.
    input wire logic reset_n_i, // Asynchronous active-low reset.
    input wire dif_pkg::dif_bus_req_t bus_i, // Register port request.
    output logic [dif_pkg::DATA_W-1:0] rdata_o, // Read data, cycle after read.
    input wire logic [dif_pkg::NUM_IN-1:0] field_input_line_i, // Field inputs.
    output logic [dif_pkg::NUM_OUT-1:0] field_output_o, // Field outputs.
    input wire dif_pkg::dif_supply_t supply_i, // Supply and fault sense.
    output dif_pkg::dif_lamps_t lamps_o, // Status lamps.
    output logic irq_o, // Edge interrupt, level.
    output logic diag_irq_o // Interrupt-lost diagnostic, level.
);
    import dif_pkg::*;

    logic [NUM_IN-1:0] filt;
    logic [NUM_IN-1:0] filt_d_reg;
    logic [CNT_W-1:0] limit [NUM_IN];
    logic [NUM_IN-1:0] rise_en_reg;
    logic [NUM_IN-1:0] fall_en_reg;
    logic [2*NUM_GRP-1:0] delay_reg;
    logic [NUM_IN-1:0] estat_reg;
    logic [NUM_IN-1:0] estat_next;
    logic [NUM_IN-1:0] lstat_reg;
    logic [NUM_IN-1:0] lstat_next;
    logic [NUM_IN-1:0] emask_reg;
    logic [NUM_IN-1:0] lmask_reg;
    logic [NUM_OUT-1:0] out_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
    logic [NUM_IN-1:0] event_hit;
    logic [NUM_IN-1:0] eclr;
    logic [NUM_IN-1:0] lclr;
    dif_lamps_t lamps_reg;

    // Per input: pick the group delay, demote 0.1ms on slow lines, then filter.
    for (genvar g = 0; g < NUM_IN; g++) begin : g_ch
        logic [1:0] sel;
        assign sel = delay_reg[2*(g/GRP_SIZE) +: 2];
        always_comb begin
            case (sel)
                DLY_0P1: limit[g] = FAST_MASK[g] ? CNT_W'(CNT_0P1) : CNT_W'(CNT_0P5);
                DLY_0P5: limit[g] = CNT_W'(CNT_0P5);
                DLY_3: limit[g] = CNT_W'(CNT_3);
                default: limit[g] = CNT_W'(CNT_15);
            endcase
        end
        dif_input_filter #(.CW(CNT_W)) u_filter (
            .clock_i(clock_i),
            .reset_n_i(reset_n_i),
            .raw_i(field_input_line_i[g]),
            .limit_i(limit[g]),
            .level_o(filt[g])
        );
    end

    // Previous filtered level, for edge detection.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            filt_d_reg <= BITS_ZERO;
        end else begin
            filt_d_reg <= filt;
        end
    end

    // Edges are taken from the filtered level so that bounce never interrupts.
    assign rise = filt & ~filt_d_reg;
    assign fall = ~filt & filt_d_reg;
    assign event_hit = (rise & rise_en_reg) | (fall & fall_en_reg);

    // Write-one-to-clear strobes for the two sticky status words.
    always_comb begin
        eclr = BITS_ZERO;
        lclr = BITS_ZERO;
        if (bus_i.wr) begin
            if (bus_i.addr == ADR_ESTAT_LO) begin
                eclr[7:0] = bus_i.wdata;
            end else if (bus_i.addr == ADR_ESTAT_HI) begin
                eclr[15:8] = bus_i.wdata;
            end else if (bus_i.addr == ADR_LSTAT_LO) begin
                lclr[7:0] = bus_i.wdata;
            end else if (bus_i.addr == ADR_LSTAT_HI) begin
                lclr[15:8] = bus_i.wdata;
            end
        end
    end

    // A new event wins over a clear in the same cycle, so none is dropped.
    always_comb begin
        estat_next = (estat_reg & ~eclr) | event_hit;
        lstat_next = (lstat_reg & ~lclr) | (event_hit & estat_reg & ~eclr);
    end

    // Sticky edge and lost status.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            estat_reg <= BITS_ZERO;
            lstat_reg <= BITS_ZERO;
        end else begin
            estat_reg <= estat_next;
            lstat_reg <= lstat_next;
        end
    end

    // Edge enables start cleared, so nothing interrupts until software selects.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_en_reg <= BITS_ZERO;
            fall_en_reg <= BITS_ZERO;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADR_RISE_LO) begin
                rise_en_reg[7:0] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_RISE_HI) begin
                rise_en_reg[15:8] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_FALL_LO) begin
                fall_en_reg[7:0] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_FALL_HI) begin
                fall_en_reg[15:8] <= bus_i.wdata;
            end
        end
    end

    // Interrupt masks and the group delay setting.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            emask_reg <= BITS_ZERO;
            lmask_reg <= BITS_ZERO;
            delay_reg <= DELAY_RST;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADR_EMASK_LO) begin
                emask_reg[7:0] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_EMASK_HI) begin
                emask_reg[15:8] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_LMASK_LO) begin
                lmask_reg[7:0] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_LMASK_HI) begin
                lmask_reg[15:8] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_DELAY) begin
                delay_reg <= bus_i.wdata;
            end
        end
    end

    // Output image: the image bytes and their readback aliases both write it.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_reg <= '0;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADR_IMG_LO || bus_i.addr == ADR_OUT_LO) begin
                out_reg[7:0] <= bus_i.wdata;
            end else if (bus_i.addr == ADR_IMG_HI || bus_i.addr == ADR_OUT_HI) begin
                out_reg[11:8] <= bus_i.wdata[3:0];
            end
        end
    end

    // Read data stands one cycle only; unmapped addresses read as zero.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= DATA_ZERO;
        end else if (!bus_i.rd) begin
            rdata_reg <= DATA_ZERO;
        end else if (bus_i.addr == ADR_IMG_LO) begin
            rdata_reg <= filt[7:0];
        end else if (bus_i.addr == ADR_IMG_HI) begin
            rdata_reg <= filt[15:8];
        end else if (bus_i.addr == ADR_RISE_LO) begin
            rdata_reg <= rise_en_reg[7:0];
        end else if (bus_i.addr == ADR_RISE_HI) begin
            rdata_reg <= rise_en_reg[15:8];
        end else if (bus_i.addr == ADR_FALL_LO) begin
            rdata_reg <= fall_en_reg[7:0];
        end else if (bus_i.addr == ADR_FALL_HI) begin
            rdata_reg <= fall_en_reg[15:8];
        end else if (bus_i.addr == ADR_DELAY) begin
            rdata_reg <= delay_reg;
        end else if (bus_i.addr == ADR_ESTAT_LO) begin
            rdata_reg <= estat_reg[7:0];
        end else if (bus_i.addr == ADR_ESTAT_HI) begin
            rdata_reg <= estat_reg[15:8];
        end else if (bus_i.addr == ADR_LSTAT_LO) begin
            rdata_reg <= lstat_reg[7:0];
        end else if (bus_i.addr == ADR_LSTAT_HI) begin
            rdata_reg <= lstat_reg[15:8];
        end else if (bus_i.addr == ADR_EMASK_LO) begin
            rdata_reg <= emask_reg[7:0];
        end else if (bus_i.addr == ADR_EMASK_HI) begin
            rdata_reg <= emask_reg[15:8];
        end else if (bus_i.addr == ADR_LMASK_LO) begin
            rdata_reg <= lmask_reg[7:0];
        end else if (bus_i.addr == ADR_LMASK_HI) begin
            rdata_reg <= lmask_reg[15:8];
        end else if (bus_i.addr == ADR_SUPPLY) begin
            rdata_reg <= {2'h0, supply_i};
        end else if (bus_i.addr == ADR_OUT_LO) begin
            rdata_reg <= out_reg[7:0];
        end else if (bus_i.addr == ADR_OUT_HI) begin
            rdata_reg <= {4'h0, out_reg[11:8]} & OUT_HI_MASK;
        end else begin
            rdata_reg <= DATA_ZERO;
        end
    end

    // Lamps are registered so that they glitch neither on supply nor input noise.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lamps_reg <= '0;
        end else begin
            lamps_reg.input_lamp <= filt;
            lamps_reg.electronics_supply_lamp <= supply_i.electronics_ok;
            lamps_reg.output_supply_lamp <= supply_i.outputs_ok;
            lamps_reg.expansion_bus_supply_lamp <= supply_i.expansion_bus_ok;
            lamps_reg.input_supply_lamp <= supply_i.inputs_ok;
            lamps_reg.sensor_supply_fault_lamp <= supply_i.sensor_supply_fault;
            lamps_reg.output_overload_fault_lamp <= supply_i.output_overload;
        end
    end

    // Outputs; the diagnostic line listens to the lost flags alone.
    assign rdata_o = rdata_reg;
    assign field_output_o = out_reg;
    assign lamps_o = lamps_reg;
    assign irq_o = |(estat_reg & emask_reg);
    assign diag_irq_o = |(lstat_reg & lmask_reg);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_read_lo;
        bus_i.rd && bus_i.addr == ADR_IMG_LO;
    endsequence

    sequence s_write_out_hi;
        bus_i.wr && bus_i.addr == ADR_IMG_HI;
    endsequence

    sequence s_read_hi;
        bus_i.rd && bus_i.addr == ADR_IMG_HI;
    endsequence

    sequence s_write_out_lo;
        bus_i.wr && bus_i.addr == ADR_IMG_LO;
    endsequence

    property p_image_low_read;
        s_read_lo |=> rdata_o == $past(filt[7:0]);
    endproperty
    a_image_low_read: assert property (p_image_low_read) else $error("Input image byte mismatch.");

    property p_rise_sets_flag;
        (rise[0] && rise_en_reg[0]) |=> estat_reg[0];
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("Rising edge flag missing.");

    property p_no_flag_without_enable;
        ((estat_reg & ~$past(estat_reg) & ~$past(rise_en_reg | fall_en_reg)) == BITS_ZERO);
    endproperty
    a_no_flag_without_enable: assert property (p_no_flag_without_enable) else $error("Flag set while disabled.");

    property p_fall_is_one_zero;
        fall[0] |-> $past(filt[0]) && !filt[0];
    endproperty
    a_fall_is_one_zero: assert property (p_fall_is_one_zero) else $error("Falling edge misdetected.");

    property p_diag_cause;
        $rose(diag_irq_o) |-> (lstat_reg != $past(lstat_reg)) || (lmask_reg != $past(lmask_reg));
    endproperty
    a_diag_cause: assert property (p_diag_cause) else $error("Diagnostic without lost flag.");

    property p_slow_never_fast;
        limit[0] != CNT_W'(CNT_0P1);
    endproperty
    a_slow_never_fast: assert property (p_slow_never_fast) else $error("Slow input given short delay.");

    property p_lamp_follows;
        ##1 lamps_o.input_lamp == $past(filt);
    endproperty
    a_lamp_follows: assert property (p_lamp_follows) else $error("Input lamp wrong.");

    property p_fault_lamps;
        ##1 (lamps_o.sensor_supply_fault_lamp == $past(supply_i.sensor_supply_fault))
            && (lamps_o.output_overload_fault_lamp == $past(supply_i.output_overload));
    endproperty
    a_fault_lamps: assert property (p_fault_lamps) else $error("Fault lamp wrong.");

    property p_output_hi_write;
        s_write_out_hi |=> field_output_o[11:8] == $past(bus_i.wdata[3:0]);
    endproperty
    a_output_hi_write: assert property (p_output_hi_write) else $error("Output byte not written.");

    property p_filter_stable;
        $changed(filt[0]) |-> $past(field_input_line_i[0], 1) == filt[0] && $past(field_input_line_i[0], 2) == filt[0];
    endproperty
    a_filter_stable: assert property (p_filter_stable) else $error("Filter took a short pulse.");

    property p_lost_flag;
        (event_hit[0] && estat_reg[0] && !eclr[0]) |=> lstat_reg[0];
    endproperty
    a_lost_flag: assert property (p_lost_flag) else $error("Lost flag not set.");

    // Read-port, flag, lamp, output and delay checks; a stale read byte would be mistaken for input state by the core.
    property p_rdata_idle;
        !bus_i.rd |=> rdata_o == DATA_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside a read.");

    property p_image_high_read;
        s_read_hi |=> rdata_o == $past(filt[15:8]);
    endproperty
    a_image_high_read: assert property (p_image_high_read) else $error("High image byte mismatch.");

    property p_fall_sets_flag;
        (fall[1] && fall_en_reg[1]) |=> estat_reg[1];
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("Falling edge flag missing.");

    property p_supply_lamps;
        ##1 {lamps_o.electronics_supply_lamp, lamps_o.output_supply_lamp, lamps_o.expansion_bus_supply_lamp,
            lamps_o.input_supply_lamp} == $past(supply_i[5:2]);
    endproperty
    a_supply_lamps: assert property (p_supply_lamps) else $error("Supply lamp wrong.");

    property p_output_lo_write;
        s_write_out_lo |=> field_output_o[7:0] == $past(bus_i.wdata);
    endproperty
    a_output_lo_write: assert property (p_output_lo_write) else $error("Low output byte not written.");

    property p_diag_needs_lost;
        diag_irq_o |-> lstat_reg != BITS_ZERO;
    endproperty
    a_diag_needs_lost: assert property (p_diag_needs_lost) else $error("Diagnostic with no lost flag.");

    property p_fast_short_delay;
        (delay_reg[1:0] == DLY_0P1) |-> limit[3] == CNT_W'(CNT_0P1);
    endproperty
    a_fast_short_delay: assert property (p_fast_short_delay) else $error("Fast input lost short delay.");
endmodule // dif_onboard_io

/* verification/dif_field_model.sv */
/*
 * Field side model: sensors and supply sense lines in front of the I/O block.
 * Assumes the bench commands levels and the field switches them at clock edges.
 */
`timescale 1ns/1ns
module dif_field_model (
    input wire logic clock_i, // System clock.
    input wire logic [15:0] level_i, // Commanded sensor levels.
    input wire logic [5:0] supply_i, // Commanded supply and fault levels.
    output logic [15:0] field_input_line_o, // Sensor lines to the block.
    output dif_pkg::dif_supply_t supply_o // Supply sense to the block.
);
    import dif_pkg::*;
    logic [15:0] lvl_reg = 16'h0000;
    logic [5:0] sup_reg = 6'h00;
    // Sensors switch cleanly at a clock edge, so pulse widths are exact cycle counts.
    always_ff @(posedge clock_i) begin
        lvl_reg <= level_i;
        sup_reg <= supply_i;
    end
    // Sensor lines are always driven; a 24 V input is never left floating here.
    assign field_input_line_o = lvl_reg;
    assign supply_o = sup_reg;
endmodule // dif_field_model

/* verification/tb_dif_onboard_io.sv */
/*
 * Testbench of the on-board digital I/O block: register port tasks and tests.
 * Assumes short delay counts (4, 8, 12, 16 cycles) in place of the real ones.
 */
`timescale 1ns/1ns
module tb_dif_onboard_io;
    import dif_pkg::*;
    localparam int L01 = 4;
    localparam int L05 = 8;
    localparam int L3 = 12;
    localparam int L15 = 16;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    dif_bus_req_t bus_i = '0;
    logic [DATA_W-1:0] rdata_o;
    logic [NUM_IN-1:0] field_input_line_i;
    logic [NUM_OUT-1:0] field_output_o;
    dif_supply_t supply_i;
    dif_lamps_t lamps_o;
    logic irq_o;
    logic diag_irq_o;
    logic [15:0] level_cmd = 16'h0000;
    logic [5:0] supply_cmd = 6'h00;
    int num_errors = 0;
    int samples_checked = 0;

    dif_onboard_io #(.CNT_0P1(L01), .CNT_0P5(L05), .CNT_3(L3), .CNT_15(L15)) u_dif_onboard_io (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .field_input_line_i(field_input_line_i), .field_output_o(field_output_o),
        .supply_i(supply_i), .lamps_o(lamps_o), .irq_o(irq_o), .diag_irq_o(diag_irq_o));
    dif_field_model u_dif_field_model (.clock_i(clock_i), .level_i(level_cmd), .supply_i(supply_cmd),
        .field_input_line_o(field_input_line_i), .supply_o(supply_i));

    // Free-running 20 MHz clock.
    always #25 clock_i = ~clock_i;

    // A write is one strobe cycle; the strobe drops at the edge that takes it.
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bus_rd(a, d);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
    endtask

    // Holds a sensor pattern for n cycles.
    task automatic drive(input logic [15:0] v, input int n);
        level_cmd <= v;
        repeat (n) @(posedge clock_i);
    endtask

    // Filter length for a delay code; slow inputs never go below the 0.5 ms count.
    function automatic int lim(input int c, input bit fast);
        return (c == 0) ? (fast ? L01 : L05) : (c == 1) ? L05 : (c == 2) ? L3 : L15;
    endfunction

    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence; widths are odd and counts even, so no pulse sits on a boundary.
    initial begin
        logic [7:0] e;
        logic [5:0] pats [2];
        pats = '{6'h2A, 6'h15};
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        chk_reg(ADR_DELAY, 8'hAA);
        chk_reg(8'h00, 8'h00);
        chk_reg(ADR_ESTAT_LO, 8'h00);
        bus_wr(ADR_IMG_LO, 8'hA5);
        bus_wr(ADR_IMG_HI, 8'hF5);
        chk_reg(ADR_OUT_HI, 8'h05);
        chk_reg(ADR_OUT_LO, 8'hA5);
        chk("outputs", 16'h05A5, {4'h0, field_output_o});
        drive(16'h8103, 30);
        chk_reg(ADR_IMG_LO, 8'h03);
        chk_reg(ADR_IMG_HI, 8'h81);
        chk("input lamps", 16'h8103, lamps_o.input_lamp);
        chk_reg(ADR_ESTAT_LO, 8'h00);
        chk_reg(ADR_ESTAT_HI, 8'h00);
        drive(16'h0000, 30);
        bus_wr(ADR_RISE_LO, 8'h01);
        bus_wr(ADR_FALL_LO, 8'h02);
        bus_wr(ADR_EMASK_LO, 8'h03);
        bus_wr(ADR_LMASK_LO, 8'h01);
        drive(16'h0002, 30);
        chk_reg(ADR_ESTAT_LO, 8'h00);
        drive(16'h0001, 30);
        chk_reg(ADR_ESTAT_LO, 8'h03);
        chk("irq", 16'h0001, {15'h0, irq_o});
        chk("diag", 16'h0000, {15'h0, diag_irq_o});
        drive(16'h0000, 30);
        drive(16'h0001, 30);
        chk_reg(ADR_LSTAT_LO, 8'h01);
        chk("diag", 16'h0001, {15'h0, diag_irq_o});
        bus_wr(ADR_ESTAT_LO, 8'h03);
        bus_wr(ADR_LSTAT_LO, 8'h01);
        chk_reg(ADR_ESTAT_LO, 8'h00);
        chk("irq", 16'h0000, {15'h0, irq_o});
        chk("diag", 16'h0000, {15'h0, diag_irq_o});
        drive(16'h0000, 30);
        bus_wr(ADR_ESTAT_LO, 8'hFF);
        // Group 0 holds slow input 0 and fast input 3; group 1 holds fast input 4.
        bus_wr(ADR_RISE_LO, 8'h19);
        for (int c = 0; c < 4; c++) begin
            bus_wr(ADR_DELAY, {6'h00, c[1:0]} | {4'h0, 2'(3 - c), 2'b00});
            for (int w = 3; w < 18; w += 2) begin
                drive(16'h0019, w);
                drive(16'h0000, 40);
                e = {3'b000, w > lim(3 - c, 1), w > lim(c, 1), 2'b00, w > lim(c, 0)};
                chk_reg(ADR_ESTAT_LO, e);
                bus_wr(ADR_ESTAT_LO, 8'hFF);
            end
        end
        foreach (pats[i]) begin
            supply_cmd <= pats[i];
            repeat (4) @(posedge clock_i);
            chk_reg(ADR_SUPPLY, {2'b00, pats[i]});
            chk("supply lamps", {10'h000, pats[i]}, {10'h000, lamps_o[5:0]});
        end
        give_verdict;
    end

    // Watchdog well beyond the few thousand cycles the tests need.
    initial begin
        repeat (10000) @(posedge clock_i);
        num_errors++;
        give_verdict;
    end
endmodule // tb_dif_onboard_io
